// file: hdl/swu_cfg.svh
// Purpose: Constants of the single-wire readout port.
// Assumes: 50 MHz system clock.
// Notes: Times are in ns; cycle counts derive from them.
`ifndef SWU_CFG_SVH
`define SWU_CFG_SVH
`define CLK_PERIOD_NS 20
`define WAKE_MIN_NS 30000
`define WAKE_MIN_CYC ((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define END_MIN_NS 30000
`define END_MIN_CYC ((`END_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_BASE 10
`define GAP_STEP 4
`define NS_PER_US 1000
`define GAP_DIV_CYC ((12 * `CLK_PERIOD_NS) / 10)
`define GAP_DEFAULT 8'h94
`define MODE_SINGLE_WIRE 3'h0
`define BIT_CNT_W 16
`endif

// file: hdl/swu_pkg.sv
// Purpose: Types of the single-wire readout port.
// Assumes: Nothing.
// Notes: State codes are one-hot.
package swu_pkg;
  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_wake = 7'h02,
    st_measure = 7'h04,
    st_tail = 7'h08,
    st_acquire = 7'h10,
    st_send = 7'h20,
    st_gap = 7'h40
  } state_t;
endpackage : swu_pkg

// file: hdl/swu_shift_if.sv
// Purpose: Link between the sequencer and the byte shifter.
// Assumes: One clock domain.
// Notes: start is a one-cycle pulse; done is a one-cycle pulse.
`timescale 1ns/1ps
interface swu_shift_if #(parameter int CW = 16);
  logic start;
  logic [7:0] data;
  logic [CW-1:0] bit_time;
  logic done;
  logic line_low;
  modport master (output start, output data, output bit_time,
                  input done, input line_low);
  modport shifter (input start, input data, input bit_time,
                   output done, output line_low);
endinterface : swu_shift_if

// file: hdl/swu_byte_tx.sv
// Purpose: Sends one asynchronous byte frame.
// Assumes: bit_time is at least 1.
// Notes: Start low, eight bits LSB first, one stop high.
`timescale 1ns/1ps
module swu_byte_tx #(parameter int CW = 16) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  swu_shift_if.shifter sh
);
  typedef struct packed {
    logic busy;
    logic [3:0] idx;
    logic [CW-1:0] cnt;
    logic [9:0] frame;
    logic done;
  } tx_state_t;
  tx_state_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!q.busy) begin
      if (sh.start) begin
        d.busy = 1'b1;
        d.idx = 4'h0;
        d.cnt = sh.bit_time;
        d.frame = {1'b1, sh.data, 1'b0}; // RL3
      end
    end else if (q.cnt <= CW'(1)) begin
      d.cnt = sh.bit_time; // RL17
      if (q.idx == 4'h9) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.idx = q.idx + 4'h1;
        d.frame = {1'b1, q.frame[9:1]}; // RL17
      end
    end else begin
      d.cnt = q.cnt - CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sh.done = q.done;
  assign sh.line_low = q.busy && !q.frame[0];
endmodule : swu_byte_tx

// file: hdl/swu_readout.sv
// Purpose: Single-wire UART readout port of a capacitance converter.
// Assumes: Open-drain line with pull-up; 50 MHz sys_clk.
// Notes: Acquisition is an external engine with a start/done pair.
//
// Summary of operation
// RL1 - Reply rate 4800 to 9600 bits per second
// RL2 - Reply carries 16-bit result, two bytes
// RL3 - One stop bit, no parity, idle high
// RL4 - Host pulse width equals wanted bit period
// RL5 - Device times pulse, uses it as period
// RL6 - Acquisition completes before any reply bit
// RL7 - Start bit, high byte, stop bit first
// RL8 - Gap, then start, low byte, stop
// RL9 - After low byte release line, idle
// RL10 - Wake on first falling edge, 30 us low
// RL11 - Measured high pulse becomes bit time
// RL12 - Host holds line low 30 us after
// RL13 - Host then floats the line
// RL14 - Gap is (10 + 4 x setting) / 1.2 us
// RL15 - Mode comes from stored setup only
// RL16 - Bit period within two percent of pulse
// RL17 - LSB first; start and stop one period
`timescale 1ns/1ps
`include "swu_cfg.svh"
module swu_readout #(
  parameter int CW = `BIT_CNT_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic single_wire_line_in,
  output logic single_wire_line_out,
  output logic single_wire_line_oe,
  input wire logic [2:0] interface_mode_select,
  input wire logic [7:0] inter_byte_gap_setting,
  output logic acq_start,
  input wire logic acq_done,
  input wire logic [15:0] acq_result,
  output logic low_power
);
  // ==========================================================
  // Elaboration checks.
  // The counter must hold the longest inter-byte gap, which needs
  // sixteen bits at a 20 ns clock.
  if (CW < 16) begin : g_cw_small
    $error("CW too small for the longest inter-byte gap");
  end
  // Wider counters only add area; the bit period never needs them.
  if (CW > 24) begin : g_cw_large
    $error("CW wider than the counters are meant to be");
  end

  // ==========================================================
  // Line input synchroniser and state.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic line_prev;
    swu_pkg::state_t st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] bit_time;
    logic [15:0] result;
    logic second;
    logic [2:0] mode;
    logic [7:0] gap_set;
    logic acq_start;
    logic tx_start;
    logic oe;
    logic low_power;
  } top_state_t;
  top_state_t q, d;

  // ==========================================================
  // Byte shifter.
  // The shifter sends one frame per start pulse and answers with done.
  swu_shift_if #(.CW(CW)) sh ();

  swu_byte_tx #(.CW(CW)) u_tx (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sh(sh)
  );

  // ==========================================================
  // Line level and edge.
  // The edge is taken between the second flop and its delayed copy,
  // so that a metastable first flop never reaches the sequencer.
  logic line;
  logic fell;
  assign line = q.sync2;
  assign fell = q.line_prev && !q.sync2;

  // ==========================================================
  // Inter-byte gap.
  // The gap is (10 + 4 x setting) / 1.2 us. Scaled to ns and divided
  // by 1.2 clock periods it becomes a whole count of cycles; the
  // remainder, under one cycle, is dropped.
  logic [31:0] gap_units;
  logic [31:0] gap_ns_scaled;
  logic [CW+1:0] gap_cyc;
  assign gap_units = 32'(`GAP_BASE) + 32'(`GAP_STEP) * 32'(q.gap_set);
  assign gap_ns_scaled = gap_units * 32'(`NS_PER_US);
  assign gap_cyc = (CW+2)'(gap_ns_scaled / 32'(`GAP_DIV_CYC)); // RL14

  assign sh.start = q.tx_start;
  assign sh.bit_time = q.bit_time; // RL5
  assign sh.data = q.second ? q.result[7:0] : q.result[15:8]; // RL2

  // ==========================================================
  // Sequencer.
  always_comb begin
    d = q;
    d.sync1 = single_wire_line_in;
    d.sync2 = q.sync1;
    d.line_prev = q.sync2;
    d.acq_start = 1'b0;
    d.tx_start = 1'b0;
    d.oe = sh.line_low;
    unique case (q.st)
      swu_pkg::st_idle: begin
        d.low_power = 1'b1;
        // Mode and gap are sampled only while idle, so that a change
        // cannot upset a reply in progress.
        d.mode = interface_mode_select; // RL15
        d.gap_set = inter_byte_gap_setting;
        if (fell && q.mode == `MODE_SINGLE_WIRE) begin // RL10
          d.st = swu_pkg::st_wake;
          d.low_power = 1'b0;
          d.cnt = '0;
        end
      end

      swu_pkg::st_wake: begin
        if (line) begin
          // Too short a wake pulse is treated as a glitch.
          d.st = (q.cnt >= CW'(`WAKE_MIN_CYC)) ? swu_pkg::st_measure
                                               : swu_pkg::st_idle; // RL10
          d.cnt = CW'(1);
        end else if (q.cnt != '1) begin
          d.cnt = q.cnt + CW'(1);
        end
      end

      swu_pkg::st_measure: begin
        if (!line) begin
          d.bit_time = q.cnt; // RL11 RL16 RL1
          d.st = swu_pkg::st_tail;
          d.cnt = '0;
        end else if (q.cnt != '1) begin
          d.cnt = q.cnt + CW'(1);
        end else begin
          // A pulse too long for the counter is dropped as a fault.
          d.st = swu_pkg::st_idle;
        end
      end

      swu_pkg::st_tail: begin
        // The trailing low is the host's to time; only its release counts.
        if (line) begin // RL13
          d.st = swu_pkg::st_acquire;
          d.acq_start = 1'b1;
        end
      end

      swu_pkg::st_acquire: begin
        // The result is held in the state until both bytes are out.
        if (acq_done) begin // RL6
          d.result = acq_result;
          d.second = 1'b0;
          d.tx_start = 1'b1; // RL7
          d.st = swu_pkg::st_send;
        end
      end

      swu_pkg::st_send: begin
        if (sh.done) begin
          if (q.second) begin
            d.st = swu_pkg::st_idle; // RL9
          end else begin
            d.st = swu_pkg::st_gap;
            d.cnt = '0;
          end
        end
      end

      swu_pkg::st_gap: begin
        // Comparing the count plus one makes the gap exactly gap_cyc long.
        if ((CW+2)'(q.cnt) + (CW+2)'(1) >= gap_cyc) begin // RL8
          d.second = 1'b1;
          d.tx_start = 1'b1;
          d.st = swu_pkg::st_send;
        end else begin
          d.cnt = q.cnt + CW'(1);
        end
      end
      default: begin
        d.st = swu_pkg::st_idle;
      end
    endcase
  end

  // ==========================================================
  // State register.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // The synchroniser starts at the idle high level of the line, so
      // that leaving reset never looks like a wake edge.
      q <= '0;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.line_prev <= 1'b1;
      q.st <= swu_pkg::st_idle;
      q.gap_set <= `GAP_DEFAULT;
      q.mode <= `MODE_SINGLE_WIRE;
      q.low_power <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs.
  // Open drain: the pin is only ever pulled low, never driven high.
  assign single_wire_line_out = 1'b0; // RL3
  assign single_wire_line_oe = q.oe;
  assign acq_start = q.acq_start;
  assign low_power = q.low_power;
endmodule : swu_readout

// file: testbench/swu_readout_checker.sv
// Purpose: Port assertions of the readout port.
// Assumes: Bound into swu_readout.
// Notes: Quiet while sys_rst is high.
`timescale 1ns/1ps
module swu_readout_checker #(parameter int CW = 16) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic single_wire_line_in,
  input wire logic single_wire_line_out,
  input wire logic single_wire_line_oe,
  input wire logic [2:0] interface_mode_select,
  input wire logic [7:0] inter_byte_gap_setting,
  input wire logic acq_start,
  input wire logic acq_done,
  input wire logic [15:0] acq_result,
  input wire logic low_power
);
  logic busy;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Busy marks the acquisition, from its start pulse to its done pulse.
  always_ff @(posedge sys_clk) begin
    busy <= !sys_rst && (acq_start || (busy && !acq_done));
  end
  out_low_a: assert property (
    !single_wire_line_out) else $error("line out high");
  idle_quiet_a: assert property (
    low_power |-> !single_wire_line_oe) else $error("drive while idle");
  acq_quiet_a: assert property (
    busy |-> !single_wire_line_oe) else $error("drive in acquisition");
  reply_start_a: assert property (
    busy && acq_done |-> ##3 single_wire_line_oe) else $error("no start");
  one_acq_a: assert property (
    acq_start |=> !acq_start [*8]) else $error("second acq start");
  line_free_a: assert property (
    acq_start |-> single_wire_line_in && !low_power) else $error("line held");
  wake_up_a: assert property (
    $fell(single_wire_line_in) && low_power && !interface_mode_select
    |-> ##[2:6] !low_power) else $error("no wake");
  mode_off_a: assert property (
    (interface_mode_select != 3'h0) [*4] ##0 low_power |=> low_power)
    else $error("woke in other mode");
  cover property (busy && acq_done);
  cover property ($rose(single_wire_line_oe));
  cover property ($fell(low_power));
endmodule : swu_readout_checker
bind swu_readout swu_readout_checker #(.CW(CW)) check (.sys_clk,
  .sys_rst, .single_wire_line_in, .single_wire_line_out,
  .single_wire_line_oe, .interface_mode_select, .inter_byte_gap_setting,
  .acq_start, .acq_done, .acq_result, .low_power);

// file: testbench/swu_host_model.sv
// Purpose: Host end of the wire; sends the trigger.
// Assumes: Pull-up on the line; host_oe high pulls it low.
// Notes: A bit_cyc of zero sends the wake low alone.
`timescale 1ns/1ps
module swu_host_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [15:0] wake_cyc,
  input wire logic [15:0] bit_cyc,
  output logic host_oe
);
  initial begin
    host_oe = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (go) begin
        host_oe <= 1'b1;
        repeat (wake_cyc) @(posedge sys_clk);
        host_oe <= 1'b0;
        if (bit_cyc != 16'h0) begin
          repeat (bit_cyc) @(posedge sys_clk);
          host_oe <= 1'b1;
          repeat (16'h640) @(posedge sys_clk);
          host_oe <= 1'b0;
        end
      end
    end
  end
endmodule : swu_host_model

// file: testbench/testbench.sv
// Purpose: Self-checking bench of the readout port.
// Assumes: 50 MHz sys_clk; outputs sampled at the falling edge.
// Notes: Bit times are shortened so that the run stays brief.
`timescale 1ns/1ps
module testbench;
  logic sys_clk, sys_rst, acq_done, go;
  logic [2:0] mode;
  logic [7:0] gap;
  logic [15:0] result, wake_cyc, bit_cyc;
  wire logic oe, line_out, acq_start, low_power, host_oe;
  wire logic line = !(oe || host_oe);
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  swu_readout dut (.sys_clk, .sys_rst, .single_wire_line_in(line),
    .single_wire_line_out(line_out), .single_wire_line_oe(oe),
    .interface_mode_select(mode), .inter_byte_gap_setting(gap),
    .acq_start, .acq_done, .acq_result(result), .low_power);
  swu_host_model host (.sys_clk, .go, .wake_cyc, .bit_cyc, .host_oe);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = !sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic trigger(logic [15:0] w, logic [15:0] t);
    @(posedge sys_clk);
    wake_cyc <= w;
    bit_cyc <= t;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
  endtask : trigger
  task automatic get_byte(int t, output logic [7:0] b, output int t0);
    for (int i = 0; i < 30000 && oe !== 1'b1; i++) @(negedge sys_clk);
    t0 = cyc;
    repeat (t / 2) @(negedge sys_clk);
    chk("start bit", 16'h1, {15'h0, oe});
    chk("line out", 16'h0, {15'h0, line_out});
    for (int i = 0; i < 8; i++) begin
      repeat (t) @(negedge sys_clk);
      b[i] = !oe;
    end
    repeat (t) @(negedge sys_clk);
    chk("stop bit", 16'h0, {15'h0, oe});
  endtask : get_byte
  task automatic read_once(int t, logic [7:0] s, logic [15:0] r);
    logic [7:0] hi, lo;
    int t0, t1, span;
    @(posedge sys_clk);
    gap <= s;
    trigger(16'h640, t[15:0]);
    for (int i = 0; i < 9000 && acq_start !== 1'b1; i++) @(negedge sys_clk);
    chk("acq start", 16'h1, {15'h0, acq_start});
    repeat (50) @(posedge sys_clk);
    result <= r;
    acq_done <= 1'b1;
    @(posedge sys_clk);
    acq_done <= 1'b0;
    get_byte(t, hi, t0);
    get_byte(t, lo, t1);
    chk("result", r, {hi, lo});
    span = 10 * t + (10 + 4 * s) * 125 / 3;
    chk("spacing", 16'h1, {15'h0, (t1 - t0 - span) * 50 <= span &&
      (span - t1 + t0) * 50 <= span});
    repeat (t) @(negedge sys_clk);
    chk("back idle", 16'h1, {15'h0, low_power && !oe});
  endtask : read_once
  task automatic short_wake;
    trigger(16'h1f4, 16'h0);
    repeat (250) @(negedge sys_clk);
    chk("woken", 16'h0, {15'h0, low_power});
    repeat (300) @(negedge sys_clk);
    chk("short low", 16'h1, {15'h0, low_power});
  endtask : short_wake
  task automatic mode_off;
    @(posedge sys_clk);
    mode <= 3'h3;
    trigger(16'h640, 16'h64);
    repeat (3400) @(negedge sys_clk);
    chk("mode off", 16'h1, {15'h0, low_power});
  endtask : mode_off
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    sys_rst = 1'b1;
    acq_done = 1'b0;
    go = 1'b0;
    mode = 3'h0;
    gap = 8'h94;
    result = 16'h0;
    wake_cyc = 16'h0;
    bit_cyc = 16'h0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    chk("reset", 16'h1, {15'h0, low_power && !oe && !acq_start});
    read_once(100, 8'h02, 16'ha53c);
    read_once(157, 8'h94, 16'h5ac3);
    short_wake();
    mode_off();
    test_done();
  end
endmodule : testbench
